// *** uoec_top.sv ***
// OUT endpoints 1 to 3 control with an AXI4-Lite register slave.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "uoec_defs.svh"
module uoec_top
	import uoec_pkg::*;
#(
	parameter int NUM_EP = 3,
	parameter int LEN_W = 10,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Received packets from the serial engine
	input wire logic pkt_valid,
	input wire logic [1:0] pkt_ep,
	input wire logic [LEN_W-1:0] pkt_len,
	input wire logic pkt_data1,
	input wire logic pkt_crc_err,
	input wire logic pkt_stuff_err,
	// Handshake back to the serial engine
	output logic hs_valid,
	output uoec_hs_type hs_code,
	// Per-endpoint event pulses
	output logic [NUM_EP-1:0] ep_event
);

	// ------------------------------------------------------------
	// Decoding functions
	// ------------------------------------------------------------
	function automatic uoec_reg_type uoec_decode(input logic [ADDR_W-1:0] a);
		uoec_reg_type r;
		r = UOEC_R_NONE;
		case (a)
			`UOEC_OFF_INDEX: r = UOEC_R_INDEX;
			`UOEC_OFF_CSR: r = UOEC_R_CSR;
			`UOEC_OFF_CFG: r = UOEC_R_CFG;
			`UOEC_OFF_CNTL: r = UOEC_R_CNTL;
			`UOEC_OFF_CNTH: r = UOEC_R_CNTH;
			default: r = UOEC_R_NONE;
		endcase
		return r;
	endfunction : uoec_decode

	function automatic logic [NUM_EP-1:0] uoec_ep_sel(input logic [1:0] n);
		logic [NUM_EP-1:0] s;
		s = '0;
		for (int k = 0; k < NUM_EP; k++) begin
			if (n == 2'(k + 1)) begin
				s[k] = 1'b1;
			end
		end
		return s;
	endfunction : uoec_ep_sel

	// ------------------------------------------------------------
	// Bus slave state
	// ------------------------------------------------------------
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [1:0] index_q;

	wire wr_go = awvalid & awready_q & wvalid & wready_q;
	wire rd_go = arvalid & arready_q;
	uoec_reg_type wr_reg;
	uoec_reg_type rd_reg;
	assign wr_reg = uoec_decode(awaddr);
	assign rd_reg = uoec_decode(araddr);
	wire wr_lane = wr_go & wstrb[0];
	wire [NUM_EP-1:0] wr_sel = uoec_ep_sel(index_q);
	wire wr_csr = wr_lane & (wr_reg == UOEC_R_CSR);
	wire wr_cfg = wr_lane & (wr_reg == UOEC_R_CFG);
	wire wr_idx = wr_lane & (wr_reg == UOEC_R_INDEX);
	wire [7:0] wbyte = wdata[7:0];

	// ------------------------------------------------------------
	// Packet classification
	// ------------------------------------------------------------
	wire pkt_bad = pkt_crc_err | pkt_stuff_err;
	wire [NUM_EP-1:0] pkt_sel = uoec_ep_sel(pkt_ep);

	// ------------------------------------------------------------
	// Per-endpoint state
	// ------------------------------------------------------------
	logic [1:0] cnt_q [NUM_EP];
	logic head_q [NUM_EP];
	logic tog_q [NUM_EP];
	logic send_stall_bit_q [NUM_EP];
	logic sent_stall_flag_q [NUM_EP];
	logic ovr_q [NUM_EP];
	logic db_q [NUM_EP];
	logic iso_q [NUM_EP];
	logic [LEN_W-1:0] len_q [NUM_EP][2];
	logic err_q [NUM_EP][2];

	logic [7:0] ep_csr [NUM_EP];
	logic [7:0] ep_cfg [NUM_EP];
	logic [LEN_W-1:0] ep_len [NUM_EP];
	logic [NUM_EP-1:0] ep_irq;
	logic [NUM_EP-1:0] ep_hs_v;
	uoec_hs_type ep_hs_c [NUM_EP];

	for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
		wire hit = pkt_valid & pkt_sel[i];
		wire csr_wr = wr_csr & wr_sel[i];
		wire cfg_wr = wr_cfg & wr_sel[i];
		wire ready = (cnt_q[i] != 2'h0);
		wire full = db_q[i] ? (cnt_q[i] == `UOEC_SLOTS) : ready;
		wire rel = ~wbyte[`UOEC_CSR_OPR] | wbyte[`UOEC_CSR_FLUSH];
		wire pop = csr_wr & ready & rel;
		wire iso = iso_q[i];
		wire stall_now = hit & ~iso & send_stall_bit_q[i];
		wire bulk_ok = ~send_stall_bit_q[i] & ~pkt_bad & ~full;
		wire tog_ok = (pkt_data1 == tog_q[i]);
		wire bulk_push = hit & ~iso & bulk_ok & tog_ok;
		wire iso_push = hit & iso & ~full;
		wire push = bulk_push | iso_push;
		wire ovr_now = hit & iso & full;
		wire wslot = head_q[i] ^ cnt_q[i][0];
		wire again = pop & (cnt_q[i] == `UOEC_SLOTS);

		// Events come from a new ready packet, a release that exposes a held packet, a sent stall or an isochronous overrun.
		assign ep_irq[i] = push | again | stall_now | ovr_now;

		// Isochronous endpoints never handshake; a corrupted bulk packet
		// gets no answer so the host retries it, unless send stall is set and it gets a stall.
		assign ep_hs_v[i] = hit & ~iso & (send_stall_bit_q[i] | ~pkt_bad);
		assign ep_hs_c[i] = send_stall_bit_q[i] ? UOEC_HS_STALL :
			(full ? UOEC_HS_NAK : UOEC_HS_ACK);

		assign ep_len[i] = len_q[i][head_q[i]];
		assign ep_csr[i] = {1'b0, sent_stall_flag_q[i], send_stall_bit_q[i], 1'b0,
			err_q[i][head_q[i]] & ready, ovr_q[i], full, ready};
		assign ep_cfg[i] = {db_q[i], iso_q[i], 6'h00};

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt_q[i] <= 2'h0;
				head_q[i] <= 1'b0;
				tog_q[i] <= 1'b0;
				send_stall_bit_q[i] <= 1'b0;
				sent_stall_flag_q[i] <= 1'b0;
				ovr_q[i] <= 1'b0;
				db_q[i] <= 1'b0;
				iso_q[i] <= 1'b0;
				len_q[i][0] <= '0;
				len_q[i][1] <= '0;
				err_q[i][0] <= 1'b0;
				err_q[i][1] <= 1'b0;
			end else begin
				cnt_q[i] <= 2'(cnt_q[i] + {1'b0, push} - {1'b0, pop});
				if (pop) begin
					head_q[i] <= ~head_q[i];
				end
				if (push) begin
					len_q[i][wslot] <= pkt_len;
					err_q[i][wslot] <= iso & pkt_bad;
				end
				if (csr_wr & wbyte[`UOEC_CSR_CLEAR_TOGGLE_BIT]) begin
					tog_q[i] <= 1'b0;
				end else if (bulk_push) begin
					tog_q[i] <= ~tog_q[i];
				end
				if (csr_wr) begin
					send_stall_bit_q[i] <= wbyte[`UOEC_CSR_SEND_STALL_BIT];
				end
				// A new event wins over a clearing write in the same cycle.
				if (stall_now) begin
					sent_stall_flag_q[i] <= 1'b1;
				end else if (csr_wr & ~wbyte[`UOEC_CSR_SENT_STALL_FLAG]) begin
					sent_stall_flag_q[i] <= 1'b0;
				end
				if (ovr_now) begin
					ovr_q[i] <= 1'b1;
				end else if (csr_wr & ~wbyte[`UOEC_CSR_OVR]) begin
					ovr_q[i] <= 1'b0;
				end
				if (cfg_wr) begin
					db_q[i] <= wbyte[`UOEC_CFG_DB];
					iso_q[i] <= wbyte[`UOEC_CFG_ISO];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Handshake and event merge
	// ------------------------------------------------------------
	logic hs_valid_q;
	uoec_hs_type hs_code_q;
	logic [NUM_EP-1:0] ep_event_q;
	logic any_hs;
	uoec_hs_type sel_hs;

	// Only one endpoint can match a packet, so a last-match select holds.
	always_comb begin
		any_hs = 1'b0;
		sel_hs = UOEC_HS_ACK;
		for (int k = 0; k < NUM_EP; k++) begin
			if (ep_hs_v[k]) begin
				any_hs = 1'b1;
				sel_hs = ep_hs_c[k];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hs_valid_q <= 1'b0;
			hs_code_q <= UOEC_HS_ACK;
			ep_event_q <= '0;
		end else begin
			hs_valid_q <= any_hs;
			hs_code_q <= sel_hs;
			ep_event_q <= ep_irq;
		end
	end

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	// Reads follow the index register, so firmware selects the endpoint first.
	// The count registers show the head packet only; a second held packet
	// stays hidden until the first one is released.
	logic [7:0] sel_csr;
	logic [7:0] sel_cfg;
	logic [LEN_W-1:0] sel_len;

	always_comb begin
		sel_csr = `UOEC_RST_BYTE;
		sel_cfg = `UOEC_RST_BYTE;
		sel_len = '0;
		for (int k = 0; k < NUM_EP; k++) begin
			if (wr_sel[k]) begin
				sel_csr = ep_csr[k];
				sel_cfg = ep_cfg[k];
				sel_len = ep_len[k];
			end
		end
	end

	wire [15:0] cnt_word = 16'(sel_len);
	wire [31:0] rd_csr = {24'h000000, sel_csr};
	wire [31:0] rd_cfg = {24'h000000, sel_cfg};
	wire [31:0] rd_idx = {30'h00000000, index_q};
	wire [31:0] rd_cntl = {24'h000000, cnt_word[7:0]};
	wire [31:0] rd_cnth = {24'h000000, cnt_word[15:8]};
	wire [31:0] rd_mux =
		(rd_reg == UOEC_R_INDEX) ? rd_idx :
		(rd_reg == UOEC_R_CSR) ? rd_csr :
		(rd_reg == UOEC_R_CFG) ? rd_cfg :
		(rd_reg == UOEC_R_CNTL) ? rd_cntl :
		(rd_reg == UOEC_R_CNTH) ? rd_cnth : 32'h00000000;
	wire [1:0] rd_resp = (rd_reg == UOEC_R_NONE) ? `UOEC_RESP_SLVERR : `UOEC_RESP_OKAY;
	wire [1:0] wr_resp = (wr_reg == UOEC_R_NONE) ? `UOEC_RESP_SLVERR : `UOEC_RESP_OKAY;

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	// Address and data are taken together in one cycle; the slave waits
	// for both, which keeps either arrival order legal.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `UOEC_RESP_OKAY;
			index_q <= `UOEC_RST_INDEX;
		end else begin
			awready_q <= awvalid & wvalid & ~awready_q & ~bvalid_q;
			wready_q <= awvalid & wvalid & ~wready_q & ~bvalid_q;
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_resp;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
			if (wr_idx) begin
				index_q <= wbyte[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rresp_q <= `UOEC_RESP_OKAY;
			rdata_q <= 32'h00000000;
		end else begin
			arready_q <= arvalid & ~arready_q & ~rvalid_q;
			if (rd_go) begin
				rvalid_q <= 1'b1;
				rresp_q <= rd_resp;
				rdata_q <= rd_mux;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output drive
	// ------------------------------------------------------------
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign hs_valid = hs_valid_q;
	assign hs_code = hs_code_q;
	assign ep_event = ep_event_q;

endmodule : uoec_top

// *** uoec_defs.svh ***
// Register offsets, field positions, reset values and response codes.
`ifndef UOEC_DEFS_SVH
`define UOEC_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define UOEC_OFF_INDEX 8'h00
`define UOEC_OFF_CSR 8'h14
`define UOEC_OFF_CFG 8'h18
`define UOEC_OFF_CNTL 8'h1C
`define UOEC_OFF_CNTH 8'h20

// ------------------------------------------------------------
// Control/status field positions
// ------------------------------------------------------------
`define UOEC_CSR_OPR 0
`define UOEC_CSR_FULL 1
`define UOEC_CSR_OVR 2
`define UOEC_CSR_DERR 3
`define UOEC_CSR_FLUSH 4
`define UOEC_CSR_SEND_STALL_BIT 5
`define UOEC_CSR_SENT_STALL_FLAG 6
`define UOEC_CSR_CLEAR_TOGGLE_BIT 7

// ------------------------------------------------------------
// Configuration field positions
// ------------------------------------------------------------
`define UOEC_CFG_ISO 6
`define UOEC_CFG_DB 7

// ------------------------------------------------------------
// Reset values and bus answers
// ------------------------------------------------------------
`define UOEC_RST_BYTE 8'h00
`define UOEC_RST_INDEX 2'h0
`define UOEC_RESP_OKAY 2'h0
`define UOEC_RESP_SLVERR 2'h2
`define UOEC_SLOTS 2'h2

`endif

// *** uoec_pkg.sv ***
// Types shared by the OUT endpoint controller.
package uoec_pkg;

	// ------------------------------------------------------------
	// Handshake codes returned to the packet engine
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		UOEC_HS_ACK,
		UOEC_HS_NAK,
		UOEC_HS_STALL
	} uoec_hs_type;

	// ------------------------------------------------------------
	// Register decode result
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		UOEC_R_NONE,
		UOEC_R_INDEX,
		UOEC_R_CSR,
		UOEC_R_CFG,
		UOEC_R_CNTL,
		UOEC_R_CNTH
	} uoec_reg_type;

endpackage : uoec_pkg

// *** uoec_monitor.sv ***
// Port checker for the OUT endpoint controller.
`timescale 1ns/1ps
`include "uoec_defs.svh"
module uoec_monitor
	import uoec_pkg::*;
#(
	parameter int NUM_EP = 3,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	// Packet link
	input wire logic pkt_valid,
	input wire logic [1:0] pkt_ep,
	input wire logic hs_valid,
	input wire uoec_hs_type hs_code,
	input wire logic [NUM_EP-1:0] ep_event
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_hs_cause: assert property (hs_valid |-> $past(pkt_valid) && $past(pkt_ep) != 2'h0)
		else $error("handshake without packet");
	chk_event_cause: assert property (|ep_event |-> $past(pkt_valid) || $past(awready))
		else $error("event without cause");
	chk_event_which: assert property (|ep_event && !$past(awready)
		|-> ep_event == NUM_EP'(1) << ($past(pkt_ep) - 2'h1)) else $error("event on wrong endpoint");
	chk_stall_event: assert property (hs_valid && hs_code == UOEC_HS_STALL |-> |ep_event)
		else $error("stall without event");
	chk_csr_zero_bits: assert property ($rose(rvalid) && $past(araddr) == `UOEC_OFF_CSR
		|-> rdata[7] == 1'b0 && rdata[4] == 1'b0) else $error("write-only status bits read set");
	chk_cfg_unused: assert property ($rose(rvalid) && $past(araddr) == `UOEC_OFF_CFG
		|-> rdata[5:0] == 6'h00) else $error("unused config bits read set");
	chk_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write not answered");
	chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	chk_rd_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	cov_stall: cover property (hs_valid && hs_code == UOEC_HS_STALL);
	cov_nak: cover property (hs_valid && hs_code == UOEC_HS_NAK);
	cov_release: cover property (|ep_event && $past(awready));
endmodule : uoec_monitor

bind uoec_top uoec_monitor #(.NUM_EP(NUM_EP), .ADDR_W(ADDR_W)) uoec_monitor_i (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
	.arvalid, .arready, .rdata, .rvalid, .rready, .pkt_valid, .pkt_ep, .hs_valid, .hs_code, .ep_event
);

// *** uoec_host_model.sv ***
// Behavioural host that sends OUT data packets and collects the answers.
`timescale 1ns/1ps
module uoec_host_model
	import uoec_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Packet link
	output logic pkt_valid,
	output logic [1:0] pkt_ep,
	output logic [9:0] pkt_len,
	output logic pkt_data1,
	output logic pkt_crc_err,
	output logic pkt_stuff_err,
	// Answers
	input wire logic hs_valid,
	input wire uoec_hs_type hs_code,
	input wire logic [2:0] ep_event
);
	logic [3:0] tog = 4'h0;
	logic [1:0] got_hs;
	logic [2:0] got_ev;
	initial begin
		pkt_valid = 1'b0;
		{pkt_ep, pkt_len, pkt_data1, pkt_crc_err, pkt_stuff_err} = '0;
	end
	// One packet per call, so a frame never carries two.
	task automatic send(input logic [1:0] ep, input logic [9:0] len, input logic bad,
		input logic [1:0] err);
		@(posedge aclk);
		pkt_valid <= 1'b1;
		pkt_ep <= ep;
		pkt_len <= len;
		pkt_data1 <= tog[ep] ^ bad;
		{pkt_stuff_err, pkt_crc_err} <= err;
		@(posedge aclk);
		// Released ep, length and data1 lines flip so that stale values cannot pass for fresh ones.
		pkt_valid <= 1'b0;
		pkt_ep <= ~ep;
		pkt_len <= ~len;
		pkt_data1 <= ~pkt_data1;
		#1;
		got_hs = hs_valid ? 2'(hs_code) : 2'h3;
		got_ev = ep_event;
		if (hs_valid && hs_code == UOEC_HS_ACK && !bad) tog[ep] = ~tog[ep];
	endtask : send
endmodule : uoec_host_model

// *** uoec_top_tb.sv ***
// Self-checking bench for the OUT endpoint controller.
`timescale 1ns/1ps
`include "uoec_defs.svh"
module uoec_top_tb;
	import uoec_pkg::*;
	localparam logic [7:0] IX = `UOEC_OFF_INDEX;
	localparam logic [7:0] CS = `UOEC_OFF_CSR;
	localparam logic [7:0] CF = `UOEC_OFF_CFG;
	localparam logic [7:0] CL = `UOEC_OFF_CNTL;
	localparam logic [7:0] CH = `UOEC_OFF_CNTH;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, hs_valid, pkt_valid, pkt_data1, pkt_crc_err, pkt_stuff_err;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [2:0] awprot, arprot, ep_event;
	logic [1:0] bresp, rresp, pkt_ep, e2;
	logic [9:0] pkt_len, l1, l2;
	uoec_hs_type hs_code;
	int n_fail = 0;
	int cmp_count = 0;
	int n_ev = 0;
	int ne;
	uoec_top uoec_top_i (
		.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .pkt_valid, .pkt_ep, .pkt_len, .pkt_data1, .pkt_crc_err, .pkt_stuff_err,
		.hs_valid, .hs_code, .ep_event
	);
	uoec_host_model uoec_host_model_i (
		.aclk, .pkt_valid, .pkt_ep, .pkt_len, .pkt_data1, .pkt_crc_err, .pkt_stuff_err,
		.hs_valid, .hs_code, .ep_event
	);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) if (|ep_event) n_ev <= n_ev + 1;
	function automatic logic [1:0] rsp(input logic [7:0] a);
		return (a inside {IX, CS, CF, CL, CH}) ? 2'h0 : 2'h2;
	endfunction : rsp
	function automatic logic [7:0] ex(input int h, input logic db, sd, st, ov, de);
		return {1'b0, st, sd, 1'b0, de && h > 0, ov, h == (db ? 2 : 1), h > 0};
	endfunction : ex
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", rsp(a), bresp);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rresp", rsp(a), rresp);
		chk("rdata", e, rdata);
	endtask : rc
	task automatic pk(input logic [1:0] e, input logic [9:0] l, input logic b,
		input logic [1:0] er, input logic [1:0] hs, input logic [2:0] ev);
		uoec_host_model_i.send(e, l, b, er);
		chk("handshake", hs, uoec_host_model_i.got_hs);
		chk("event", ev, uoec_host_model_i.got_ev);
	endtask : pk
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		tally_and_finish;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
		{wdata, wstrb, awprot, arprot} = '0;
		void'($urandom(4511));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wr(IX, 1);
		rc(CS, 0);
		rc(CF, 0);
		rc(8'h40, 0);
		wr(8'h40, 32'hFF);
		wr(CF, 32'hFF, 4'h0);
		rc(CF, 0);
		wr(CF, 32'hFF);
		rc(CF, 32'hC0);
		for (int e = 1; e < 4; e++) begin
			l1 = 10'($urandom);
			l2 = 10'($urandom);
			wr(IX, 8'(e));
			wr(CF, 32'h80);
			pk(2'(e), l1, 0, 0, 0, 3'(1 << (e - 1)));
			pk(2'(e), l2, 0, 0, 0, 3'(1 << (e - 1)));
			pk(2'(e), l2, 0, 0, 1, 0);
			rc(CS, ex(2, 1, 0, 0, 0, 0));
			rc(CL, l1[7:0]);
			rc(CH, l1[9:8]);
			ne = n_ev;
			wr(CS, 0);
			rc(CS, ex(1, 1, 0, 0, 0, 0));
			chk("release event", 1, n_ev - ne);
			rc(CL, l2[7:0]);
			wr(CS, 0);
			rc(CS, 0);
		end
		wr(IX, 1);
		wr(CF, 0);
		pk(1, l1, 0, 0, 0, 1);
		wr(CS, 0);
		pk(1, l1, 1, 0, 0, 0);
		rc(CS, 0);
		wr(CS, 32'h80);
		uoec_host_model_i.tog[1] = 1'b0;
		pk(1, l1, 0, 0, 0, 1);
		rc(CS, ex(1, 0, 0, 0, 0, 0));
		wr(CS, 0);
		wr(CS, 32'h20);
		pk(1, l1, 0, 0, 2, 1);
		pk(1, l1, 0, 0, 2, 1);
		rc(CS, 32'h60);
		wr(CS, 0);
		pk(1, l2, 0, 0, 0, 1);
		wr(CS, 0);
		wr(CF, 32'h40);
		wr(CS, 32'h20);
		pk(1, l1, 0, 2'h1, 3, 1);
		rc(CS, ex(1, 0, 1, 0, 0, 1));
		pk(1, l2, 0, 0, 3, 1);
		rc(CS, ex(1, 0, 1, 0, 1, 1));
		rc(CL, l1[7:0]);
		wr(CS, 32'h35);
		rc(CS, ex(0, 0, 1, 0, 1, 0));
		wr(CS, 32'h01);
		wr(CS, 32'h11);
		rc(CS, 0);
		pk(1, l2, 0, 2'h2, 3, 1);
		rc(CS, ex(1, 0, 0, 0, 0, 1));
		wr(CS, 0);
		rc(CS, 0);
		for (int i = 0; i < 16; i++) begin
			e2 = 2'($urandom_range(3, 2));
			l1 = 10'($urandom);
			wr(IX, 8'(e2));
			pk(e2, l1, 0, 0, 0, 3'(1 << (e2 - 1)));
			rc(CH, l1[9:8]);
			wr(CS, 0);
		end
		tally_and_finish;
	end
endmodule : uoec_top_tb
